// ===== hdl/lsst_pkg.sv
// constants and types shared by the line scan timing generator, its checks and its bench
package lsst_pkg;
  localparam int PIX_W = 12;
  localparam int ADDR_W = 10;
  localparam logic [ADDR_W-1:0] LAST_SHORT = 10'h1ff;
  localparam logic [ADDR_W-1:0] LAST_LONG = 10'h3ff;
  localparam int FIFO_DEPTH = 32;
  localparam int CLK_PERIOD_NS = 50;
  localparam int START_LOW_MIN_CLKS = 15;
  localparam int START_HIGH_MIN_CLKS = 8;
  localparam int START_INTERVAL_MIN_CLKS = 23;
  localparam int SYNC_STAGES = 2;
  localparam int FIRST_PIXEL_LAT = 2;
  localparam logic [ADDR_W-1:0] ADDR_RST = 10'h000;

  typedef struct packed {
    logic last;
    logic [PIX_W-1:0] pix;
  } lsst_video_t;

  typedef enum logic [0:0] {SEQ_IDLE, SEQ_SCAN} lsst_state_t;
endpackage : lsst_pkg

// ===== hdl/lsst_fifo.sv
// fifo between pixel array readout and the video output
`timescale 1ns/1ps
module lsst_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 32
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic flush, // drops all entries
  input wire logic in_valid, // write request
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // a word is waiting
  input wire logic out_ready, // reader takes the word
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];

  // ***********************
  // storage
  // ***********************
  genvar g;
  for (g = 0; g < DEPTH; g++) begin : g_ent
    always_ff @(posedge clk) begin
      if (ce && push && wr_q == AW'(g)) begin
        mem_q[g] <= in_data;
      end
    end
  end

  // ***********************
  // pointers
  // ***********************
  always_ff @(posedge clk) begin
    if (!rst_n || (ce && flush)) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : lsst_fifo

// ===== hdl/lsst_scan.sv
// line sensor scan timing generator: start pulse to pixel stream and end of scan
`timescale 1ns/1ps
module lsst_scan (
  input wire logic clk, // sensor clock, one pixel per edge
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic scan_start_pulse, // start pin, asynchronous
  input wire logic line_long, // variant strap: 1 = 1024 pixels, asynchronous
  output logic integrate_en, // global integration enable to all pixels
  output logic charge_hold, // one-cycle global charge transfer at start fall
  output logic [lsst_pkg::ADDR_W-1:0] pixel_addr, // pixel array read address
  input wire logic [lsst_pkg::PIX_W-1:0] pixel_data, // pixel value at pixel_addr
  output logic video_valid, // pixel present on video
  input wire logic video_ready, // controller samples this cycle
  output lsst_pkg::lsst_video_t video, // pixel value with last marker
  output logic scan_done_flag, // one-cycle end of scan
  output logic scan_busy // scan in progress
);
  // ***********************
  // declarations
  // ***********************
  // start pin: two synchroniser stages, then one delay stage for the edge detector
  logic start_m_q;
  logic start_s_q;
  logic start_d_q;
  // variant strap: two synchroniser stages, latched at each scan start
  logic long_m_q;
  logic long_s_q;
  logic long_q;
  // sequencer
  lsst_pkg::lsst_state_t state_q;
  lsst_pkg::lsst_state_t state_d;
  logic [lsst_pkg::ADDR_W-1:0] addr_q;
  logic [lsst_pkg::ADDR_W-1:0] addr_d;
  // shutter
  logic integ_q;
  logic hold_q;
  // end of scan
  logic done_q;
  logic done_d;
  // output queue
  logic fifo_in_ready;
  logic fifo_out_valid;
  lsst_pkg::lsst_video_t fifo_out;
  lsst_pkg::lsst_video_t wr_word;

  // ***********************
  // pin synchronisers
  // ***********************
  // only the second stage of each pair is read by logic; the first may be metastable
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_m_q <= 1'b0;
      start_s_q <= 1'b0;
    end else if (ce) begin
      start_m_q <= scan_start_pulse;
      start_s_q <= start_m_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      long_m_q <= 1'b0;
      long_s_q <= 1'b0;
    end else if (ce) begin
      long_m_q <= line_long;
      long_s_q <= long_m_q;
    end
  end

  // ***********************
  // start edge detector
  // ***********************
  // the delay stage resets low, so a pin already high at reset release gives no fall
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      start_d_q <= 1'b0;
    end else if (ce) begin
      start_d_q <= start_s_q;
    end
  end

  // start fall seen on this edge: this edge is clock 1
  wire start_fall = start_d_q & ~start_s_q;

  // ***********************
  // sequencer decode
  // ***********************
  // timing from the pin falling: two synchroniser edges, then clock 1 on the third;
  // pixel 0 is read and queued on clock 2 and stands on video from then on
  wire [lsst_pkg::ADDR_W-1:0] last_addr = long_q ? lsst_pkg::LAST_LONG
                                                 : lsst_pkg::LAST_SHORT;
  wire at_last = (addr_q == last_addr);
  wire scanning = (state_q == lsst_pkg::SEQ_SCAN);
  // a full queue stalls the address instead of dropping a pixel
  wire push = scanning & fifo_in_ready & ~start_fall;
  wire pop = fifo_out_valid & video_ready;

  assign wr_word.pix = pixel_data;
  assign wr_word.last = at_last;

  // ***********************
  // scan sequencer
  // ***********************
  // an abort wins over a push in the same cycle; pixel 0 of the new line goes one edge later
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    case (state_q)
      lsst_pkg::SEQ_IDLE: begin
        if (start_fall) begin
          state_d = lsst_pkg::SEQ_SCAN;
          addr_d = lsst_pkg::ADDR_RST;
        end
      end
      lsst_pkg::SEQ_SCAN: begin
        if (start_fall) begin
          addr_d = lsst_pkg::ADDR_RST;
        end else if (push) begin
          addr_d = addr_q + 1'b1;
          if (at_last) state_d = lsst_pkg::SEQ_IDLE;
        end
      end
      default: begin
        state_d = lsst_pkg::SEQ_IDLE;
        addr_d = lsst_pkg::ADDR_RST;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= lsst_pkg::SEQ_IDLE;
      addr_q <= lsst_pkg::ADDR_RST;
    end else if (ce) begin
      state_q <= state_d;
      addr_q <= addr_d;
    end
  end

  // variant fixed for the whole scan, so a strap change mid-line cannot cut it short
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      long_q <= 1'b0;
    end else if (ce && start_fall) begin
      long_q <= long_s_q;
    end
  end

  // ***********************
  // shutter
  // ***********************
  // every pixel sees the same enable and the same hold, so no rolling skew
  // integration ends at clock 1, the same edge that launches the scan
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      integ_q <= 1'b0;
    end else if (ce) begin
      integ_q <= start_s_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hold_q <= 1'b0;
    end else if (ce) begin
      hold_q <= start_fall;
    end
  end

  // ***********************
  // output queue
  // ***********************
  // flush on abort so no stale pixels from the old line leak into the new one
  // one queue entry per pixel plus its last marker
  lsst_fifo #(
    .WIDTH($bits(lsst_pkg::lsst_video_t)),
    .DEPTH(lsst_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .flush(start_fall),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(wr_word),
    .out_valid(fifo_out_valid),
    .out_ready(video_ready),
    .out_data(fifo_out)
  );

  // ***********************
  // end of scan
  // ***********************
  // an abort on the edge that takes the last pixel cancels the pulse: that line is void
  wire pop_last = pop & fifo_out.last;
  assign done_d = pop_last & ~start_fall;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= done_d;
    end
  end

  // ***********************
  // outputs
  // ***********************
  assign integrate_en = integ_q;
  assign charge_hold = hold_q;
  assign pixel_addr = addr_q;
  assign video_valid = fifo_out_valid;
  assign video = fifo_out;
  assign scan_done_flag = done_q;

  // ***********************
  // scan status
  // ***********************
  // busy covers the drain of the queue as well, so the line is not over until the last pixel
  assign scan_busy = scanning | fifo_out_valid;
endmodule : lsst_scan

// ===== verification/lsst_scan_sva.sv
// concurrent checks on the ports of the scan timing generator
`timescale 1ns/1ps
module lsst_scan_chk (
  input wire logic clk, // sensor clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic scan_start_pulse, // start pin
  input wire logic line_long, // variant strap
  input wire logic integrate_en, // global integration
  input wire logic charge_hold, // charge transfer pulse
  input wire logic [lsst_pkg::ADDR_W-1:0] pixel_addr, // array address
  input wire logic [lsst_pkg::PIX_W-1:0] pixel_data, // array data
  input wire logic video_valid, // pixel present
  input wire logic video_ready, // pixel taken
  input wire lsst_pkg::lsst_video_t video, // pixel word
  input wire logic scan_done_flag, // end of scan
  input wire logic scan_busy // scan running
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  // frozen clock enable stretches every figure, so those cycles are not judged
  default disable iff (!rst_n || !ce);
  sequence s_fall;
    $fell(scan_start_pulse);
  endsequence
  sequence s_last;
    video_valid && video_ready && video.last;
  endsequence
  property p_int_on;
    $rose(scan_start_pulse) |-> ##[2:4] integrate_en;
  endproperty
  a_int_on: assert property (p_int_on) else $error("integration late");
  property p_int_off;
    s_fall |-> ##[2:4] !integrate_en;
  endproperty
  a_int_off: assert property (p_int_off) else $error("integration not ended");
  property p_hold;
    s_fall |-> ##[2:5] charge_hold;
  endproperty
  a_hold: assert property (p_hold) else $error("no charge transfer");
  property p_hold_one;
    charge_hold |=> !charge_hold;
  endproperty
  a_hold_one: assert property (p_hold_one) else $error("transfer too long");
  property p_first;
    charge_hold |-> ##[0:2] video_valid && !video.last;
  endproperty
  a_first: assert property (p_first) else $error("first pixel late");
  // an abort flushes the queue; the charge transfer pulse marks the edge after it
  property p_stand;
    video_valid && !video_ready |=> (video_valid && $stable(video)) || charge_hold;
  endproperty
  a_stand: assert property (p_stand) else $error("pixel not held");
  property p_done;
    s_last |=> scan_done_flag || charge_hold;
  endproperty
  a_done: assert property (p_done) else $error("no end of scan");
  property p_done_one;
    scan_done_flag |=> !scan_done_flag;
  endproperty
  a_done_one: assert property (p_done_one) else $error("end pulse long");
  property p_idle;
    $fell(scan_busy) |-> scan_done_flag;
  endproperty
  a_idle: assert property (p_idle) else $error("line ended without end of scan");
endmodule : lsst_scan_chk

bind lsst_scan lsst_scan_chk i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .scan_start_pulse(scan_start_pulse), .line_long(line_long), .integrate_en(integrate_en),
  .charge_hold(charge_hold), .pixel_addr(pixel_addr), .pixel_data(pixel_data),
  .video_valid(video_valid), .video_ready(video_ready), .video(video),
  .scan_done_flag(scan_done_flag), .scan_busy(scan_busy));

// ===== verification/lsst_pix_model.sv
// pixel array model answering the read address
`timescale 1ns/1ps
module lsst_pix_model (
  input wire logic [lsst_pkg::ADDR_W-1:0] pixel_addr, // read address
  output logic [lsst_pkg::PIX_W-1:0] pixel_data // value at that address
);
  // a distinct value per address exposes skipped or repeated pixels
  assign pixel_data = {2'h0, pixel_addr} ^ 12'h5a5;
endmodule : lsst_pix_model

// ===== verification/testbench.sv
// self-checking bench for the scan timing generator
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module testbench;
  logic clk = 0, rst_n = 0, start_pin = 1, strap = 0, rdy = 0, ce = 1;
  logic ie, ch, vv, done, busy;
  logic [lsst_pkg::ADDR_W-1:0] addr;
  logic [lsst_pkg::PIX_W-1:0] pd;
  lsst_pkg::lsst_video_t vid;
  int fails = 0, cmp_count = 0;
  lsst_scan i_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .scan_start_pulse(start_pin),
    .line_long(strap), .integrate_en(ie), .charge_hold(ch), .pixel_addr(addr),
    .pixel_data(pd), .video_valid(vv), .video_ready(rdy), .video(vid),
    .scan_done_flag(done), .scan_busy(busy));
  lsst_pix_model i_pix (.pixel_addr(addr), .pixel_data(pd));
  // ****
  // tasks
  // ****
  initial forever #25 clk = ~clk;
  function automatic logic [11:0] exp_pix(input int i);
    return {2'h0, i[9:0]} ^ 12'h5a5;
  endfunction : exp_pix
  task automatic pulse(input logic l);
    strap = l;
    repeat (10) @(negedge clk);
    start_pin = 0;
    repeat (5) @(negedge clk);
    `CHK("integrate_en", 1'b0, ie)
    repeat (11) @(negedge clk);
    start_pin = 1;
    repeat (5) @(negedge clk);
    `CHK("integrate_en", 1'b1, ie)
    `CHK("scan_busy", 1'b1, busy)
  endtask : pulse
  // stalling the reader fills the fifo, so the address stall is exercised too
  task automatic collect(input int n, input bit stall);
    int i, k;
    i = 0;
    for (k = 0; k < 4 * n + 100 && i < n; k++) begin
      @(negedge clk);
      rdy = stall ? k[2] : 1'b1;
      if (vv && rdy) begin
        `CHK("pix", exp_pix(i), vid.pix)
        `CHK("last", i == n - 1, vid.last)
        i++;
      end
    end
    @(negedge clk);
    rdy = 0;
    `CHK("count", n, i)
    `CHK("scan_done_flag", 1'b1, done)
  endtask : collect
  task automatic t_short;
    pulse(0);
    collect(512, 0);
    @(negedge clk);
    `CHK("scan_busy", 1'b0, busy)
  endtask : t_short
  task automatic t_long;
    pulse(1);
    collect(1024, 1);
  endtask : t_long
  // the freeze comes while the queue still fills, so a running address would show it
  task automatic t_abort;
    logic [lsst_pkg::ADDR_W-1:0] a0;
    pulse(0);
    a0 = addr;
    ce = 0;
    rdy = 1;
    repeat (10) @(negedge clk);
    `CHK("pixel_addr", a0, addr)
    `CHK("video", exp_pix(0), vid.pix)
    rdy = 0;
    ce = 1;
    repeat (60) @(negedge clk);
    pulse(0);
    collect(512, 0);
  endtask : t_abort
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    `CHK("video_valid", 1'b0, vv)
    t_short;
    t_long;
    t_abort;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule : testbench
